/* File: bst_pkg.sv */
// package of constants and types for the boundary-scan test access port
//
// Overview of operation
// [RQ1] instructions: identify, bypass, sample/preload, extest and a core reset instruction
// [RQ2] test-logic reset loads the identify instruction, so first data scan shows id
// [RQ3] scan chain drives and observes every digital pin and analog boundary signal
// [RQ4] data registers: bypass, identification, reset and boundary chain
// [RQ5] bypass routes tdi to tdo through the one-bit shortest path
// [RQ6] core held in reset by low reset pin or reset instruction with bit set
// [RQ7] while core reset is active all pin output enables drop at once; under extest the update latches set them instead
// [RQ8] extest samples pins into chain and drives pins from update latches
// [RQ9] extest drives latch values on pins as soon as the instruction updates
// [RQ10] tester preloads safe values with sample/preload before first extest
// [RQ11] sample/preload snapshots pins while the core keeps running normally
// [RQ12] port works only with enable fuse programmed and disable bit cleared
// [RQ13] scan logic runs on tck alone; chip clock may be slow or stopped
// [RQ14] tester should keep core in reset during boundary test
// [RQ15] five tck periods with tms high reach test-logic reset from anywhere
// [RQ16] bypass bit captures zero and shifts one bit per tck
package bst_pkg;

	localparam int BST_IR_W = 4;
	localparam logic [3:0] BST_IR_EXTEST = 4'h0;
	localparam logic [3:0] BST_IR_IDCODE = 4'h1;
	localparam logic [3:0] BST_IR_SAMPLE = 4'h2;
	localparam logic [3:0] BST_IR_CORE_RESET = 4'hC;
	localparam logic [3:0] BST_IR_BYPASS = 4'hF;
	// capture pattern of the instruction register, low bits 01 as usual
	localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
	// arbitrary identification value
	localparam logic [31:0] BST_IDCODE_VAL = 32'h0000_1001;
	localparam int BST_ID_W = 32;
	localparam int BST_PINS = 8;

	typedef enum logic [3:0] {
		BST_TLR = 4'h0,
		BST_RTI = 4'h1,
		BST_SEL_DR = 4'h2,
		BST_CAP_DR = 4'h3,
		BST_SH_DR = 4'h4,
		BST_EX1_DR = 4'h5,
		BST_PAU_DR = 4'h6,
		BST_EX2_DR = 4'h7,
		BST_UPD_DR = 4'h8,
		BST_SEL_IR = 4'h9,
		BST_CAP_IR = 4'hA,
		BST_SH_IR = 4'hB,
		BST_EX1_IR = 4'hC,
		BST_PAU_IR = 4'hD,
		BST_EX2_IR = 4'hE,
		BST_UPD_IR = 4'hF
	} bst_state_t;

	// one pin seen from the core or from the pad
	typedef struct packed {
		logic out;
		logic oe;
	} bst_drive_t;

endpackage

/* File: bst_fsm.sv */
// tap controller state machine
`timescale 1ns/100ps
module bst_fsm
	import bst_pkg::*;
(
	input wire logic i_tck,
	input wire logic i_trst,
	input wire logic i_tms,
	output bst_state_t o_state
);

	bst_state_t state_q;
	bst_state_t state_d;

	// tms high from every state walks toward reset within five edges
	always_comb begin // see [RQ15]
		unique case (state_q)
			BST_TLR: state_d = i_tms ? BST_TLR : BST_RTI;
			BST_RTI: state_d = i_tms ? BST_SEL_DR : BST_RTI;
			BST_SEL_DR: state_d = i_tms ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: state_d = i_tms ? BST_EX1_DR : BST_SH_DR;
			BST_SH_DR: state_d = i_tms ? BST_EX1_DR : BST_SH_DR;
			BST_EX1_DR: state_d = i_tms ? BST_UPD_DR : BST_PAU_DR;
			BST_PAU_DR: state_d = i_tms ? BST_EX2_DR : BST_PAU_DR;
			BST_EX2_DR: state_d = i_tms ? BST_UPD_DR : BST_SH_DR;
			BST_UPD_DR: state_d = i_tms ? BST_SEL_DR : BST_RTI;
			BST_SEL_IR: state_d = i_tms ? BST_TLR : BST_CAP_IR;
			BST_CAP_IR: state_d = i_tms ? BST_EX1_IR : BST_SH_IR;
			BST_SH_IR: state_d = i_tms ? BST_EX1_IR : BST_SH_IR;
			BST_EX1_IR: state_d = i_tms ? BST_UPD_IR : BST_PAU_IR;
			BST_PAU_IR: state_d = i_tms ? BST_EX2_IR : BST_PAU_IR;
			BST_EX2_IR: state_d = i_tms ? BST_UPD_IR : BST_SH_IR;
			BST_UPD_IR: state_d = i_tms ? BST_SEL_DR : BST_RTI;
		endcase
	end

	always_ff @(posedge i_tck) begin
		if (i_trst) begin
			state_q <= BST_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_state = state_q;

endmodule // bst_fsm

/* File: bst_tap.sv */
// boundary-scan test access port top level
`timescale 1ns/100ps
module bst_tap
	import bst_pkg::*;
#(
	parameter int NPINS = BST_PINS,
	parameter logic [31:0] IDCODE = BST_IDCODE_VAL
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	output logic o_tdo,
	output logic o_tdo_oe,
	input wire logic i_tap_enable_fuse,
	input wire logic i_tap_disable_bit,
	input wire logic i_reset_pin_n,
	input wire bst_drive_t [NPINS-1:0] i_core_drive,
	output logic [NPINS-1:0] o_core_in,
	input wire logic [NPINS-1:0] i_pad_in,
	output logic [NPINS-1:0] o_pad_out,
	output logic [NPINS-1:0] o_pad_oe,
	input wire logic i_ana_obs,
	output logic o_ana_drv,
	output logic o_core_reset
);

	// ----------------------------------------------------------------
	// chain layout
	// ----------------------------------------------------------------
	// per pin: input, output, enable cells; plus one analog observe/drive pair
	localparam int BSR_W = 3 * NPINS + 2;

	function automatic bst_drive_t cell_drive(input logic [BSR_W-1:0] r, input int p);
		bst_drive_t d;
		d.out = r[3 * p + 1];
		d.oe = r[3 * p + 2];
		return d;
	endfunction

	// ----------------------------------------------------------------
	// tap enable, synchronised into the tck domain
	// ----------------------------------------------------------------
	// the enable inputs live on the chip clock; tck only crosses their level
	logic en_meta_q;
	logic en_sync_q;
	wire tap_en_raw = i_tap_enable_fuse & ~i_tap_disable_bit; // see [RQ12]
	always_ff @(posedge i_tck) begin
		en_meta_q <= tap_en_raw;
		en_sync_q <= en_meta_q;
	end
	wire tap_off = ~en_sync_q; // see [RQ12]

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	// everything below except the core reset crossing runs on tck only, no chip clock needed
	bst_state_t st;
	bst_fsm u_fsm ( // see [RQ13]
		.i_tck(i_tck),
		.i_trst(tap_off),
		.i_tms(i_tms),
		.o_state(st)
	);

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	logic [BST_IR_W-1:0] ir_sh_q;
	logic [BST_IR_W-1:0] ir_q;
	always_ff @(posedge i_tck) begin
		if (tap_off || st == BST_TLR) begin
			ir_q <= BST_IR_IDCODE; // see [RQ2]
			ir_sh_q <= BST_IR_CAPTURE;
		end else begin
			if (st == BST_CAP_IR) begin
				ir_sh_q <= BST_IR_CAPTURE;
			end else if (st == BST_SH_IR) begin
				ir_sh_q <= {i_tdi, ir_sh_q[BST_IR_W-1:1]};
			end
			if (st == BST_UPD_IR) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	// unknown codes act as bypass
	wire sel_extest = (ir_q == BST_IR_EXTEST); // see [RQ1]
	wire sel_sample = (ir_q == BST_IR_SAMPLE);
	wire sel_id = (ir_q == BST_IR_IDCODE);
	wire sel_rst = (ir_q == BST_IR_CORE_RESET);
	wire sel_bsr = sel_extest | sel_sample;
	wire sel_byp = ~(sel_bsr | sel_id | sel_rst);

	// ----------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------
	logic byp_q;
	logic [BST_ID_W-1:0] id_q;
	logic rst_sh_q;
	logic rst_q;
	logic [BSR_W-1:0] bsr_sh_q;
	logic [BSR_W-1:0] bsr_upd_q;
	logic [BSR_W-1:0] bsr_cap;

	always_comb begin
		bsr_cap = '0;
		for (int p = 0; p < NPINS; p++) begin
			bsr_cap[3 * p] = i_pad_in[p]; // see [RQ8] [RQ11]
			bsr_cap[3 * p + 1] = i_core_drive[p].out;
			bsr_cap[3 * p + 2] = i_core_drive[p].oe;
		end
		bsr_cap[BSR_W-2] = i_ana_obs; // see [RQ3]
		bsr_cap[BSR_W-1] = bsr_upd_q[BSR_W-1];
	end

	wire cap_dr = (st == BST_CAP_DR);
	wire sh_dr = (st == BST_SH_DR);
	wire upd_dr = (st == BST_UPD_DR);

	always_ff @(posedge i_tck) begin
		if (sel_byp && cap_dr) begin
			byp_q <= 1'b0; // see [RQ16]
		end else if (sel_byp && sh_dr) begin
			byp_q <= i_tdi; // see [RQ5] [RQ16]
		end
		if (sel_id && cap_dr) begin
			id_q <= IDCODE;
		end else if (sel_id && sh_dr) begin
			id_q <= {i_tdi, id_q[BST_ID_W-1:1]};
		end
		if (sel_rst && cap_dr) begin
			rst_sh_q <= rst_q;
		end else if (sel_rst && sh_dr) begin
			rst_sh_q <= i_tdi;
		end
		if (sel_bsr && cap_dr) begin
			bsr_sh_q <= bsr_cap;
		end else if (sel_bsr && sh_dr) begin
			bsr_sh_q <= {i_tdi, bsr_sh_q[BSR_W-1:1]}; // see [RQ4]
		end
	end

	// boundary update latches keep their value across reset so a preload survives; the reset latch clears
	always_ff @(posedge i_tck) begin
		if (tap_off || st == BST_TLR) begin
			rst_q <= 1'b0;
		end else if (upd_dr && sel_rst) begin
			rst_q <= rst_sh_q;
		end
		if (upd_dr && sel_bsr) begin
			bsr_upd_q <= bsr_sh_q; // see [RQ10]
		end
	end

	// ----------------------------------------------------------------
	// tdo, on the falling edge of tck
	// ----------------------------------------------------------------
	wire dr_bit = sel_byp ? byp_q : sel_id ? id_q[0] : sel_rst ? rst_sh_q : bsr_sh_q[0];
	wire tdo_d = (st == BST_SH_IR) ? ir_sh_q[0] : dr_bit;
	wire tdo_en_d = (st == BST_SH_IR) | sh_dr;
	logic tdo_q;
	logic tdo_oe_q;
	always_ff @(negedge i_tck) begin
		if (tap_off) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_en_d;
		end
	end
	assign o_tdo = tdo_q;
	assign o_tdo_oe = tdo_oe_q;

	// ----------------------------------------------------------------
	// core reset, crossed to the chip clock
	// ----------------------------------------------------------------
	wire tap_rst = sel_rst & rst_q; // see [RQ6]
	logic rst_meta_q;
	logic rst_sync_q;
	logic pin_meta_q;
	logic pin_sync_q;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			rst_meta_q <= tap_rst;
			rst_sync_q <= rst_meta_q;
			pin_meta_q <= i_reset_pin_n;
			pin_sync_q <= pin_meta_q;
		end
	end
	assign o_core_reset = i_srst | rst_sync_q | ~pin_sync_q; // see [RQ6] [RQ14]

	// ----------------------------------------------------------------
	// pad multiplexing
	// ----------------------------------------------------------------
	// the tck-side reset term gates the pads directly so release of drive
	// does not wait for a stopped chip clock
	wire core_rst_now = tap_rst | ~i_reset_pin_n | i_srst;
	wire drive_test = sel_extest & en_sync_q; // see [RQ9]

	always_comb begin
		bst_drive_t upd_cell;
		upd_cell = '0;
		for (int p = 0; p < NPINS; p++) begin
			upd_cell = cell_drive(bsr_upd_q, p);
			if (drive_test) begin
				o_pad_out[p] = upd_cell.out; // see [RQ8]
				o_pad_oe[p] = upd_cell.oe;
			end else begin
				o_pad_out[p] = i_core_drive[p].out; // see [RQ11]
				o_pad_oe[p] = i_core_drive[p].oe & ~core_rst_now; // see [RQ7]
			end
		end
	end

	// the core keeps seeing the real pad levels in every mode
	assign o_core_in = i_pad_in; // see [RQ11]
	assign o_ana_drv = drive_test ? bsr_upd_q[BSR_W-1] : 1'b0; // see [RQ3]

endmodule // bst_tap

/* File: bst_tap_assertions.sv */
// concurrent checks on the boundary-scan port pins
`timescale 1ns/100ps
module bst_tap_assertions
	import bst_pkg::*;
#(
	parameter int NPINS = BST_PINS,
	parameter logic [31:0] IDCODE = BST_IDCODE_VAL
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	input wire logic i_tap_enable_fuse,
	input wire logic i_tap_disable_bit,
	input wire logic i_reset_pin_n,
	input wire bst_drive_t [NPINS-1:0] i_core_drive,
	input wire logic [NPINS-1:0] o_core_in,
	input wire logic [NPINS-1:0] i_pad_in,
	input wire logic [NPINS-1:0] o_pad_out,
	input wire logic [NPINS-1:0] o_pad_oe,
	input wire logic i_ana_obs,
	input wire logic o_ana_drv,
	input wire logic o_core_reset
);
	logic dis;
	// the off request crosses two tck flops, so checks on it allow a few edges
	assign dis = !i_tap_enable_fuse || i_tap_disable_bit;
	chk_pin_reset: assert property (@(posedge i_clk) disable iff (i_srst)
		!i_reset_pin_n [*3] |-> o_core_reset) else $error("pin reset late");
	chk_core_in: assert property (@(posedge i_clk) disable iff (i_srst)
		o_core_in == i_pad_in) else $error("core input wrong");
	chk_off_quiet: assert property (@(posedge i_tck) disable iff (i_srst)
		dis [*5] |-> !o_tdo_oe && !o_tdo) else $error("tdo on while off");
	chk_id_first: assert property (@(posedge i_tck) disable iff (dis)
		i_tms [*5] ##1 !i_tms ##1 i_tms ##1 !i_tms [*2] |=> o_tdo_oe && o_tdo == IDCODE[0])
		else $error("first bit not id");
	chk_ir_capture: assert property (@(posedge i_tck) disable iff (dis)
		i_tms [*5] ##1 !i_tms ##1 i_tms [*2] ##1 !i_tms [*2] |=> o_tdo_oe && o_tdo == BST_IR_CAPTURE[0])
		else $error("ir capture bit");
	chk_shift_exit: assert property (@(posedge i_tck) disable iff (dis)
		o_tdo_oe && i_tms |=> !o_tdo_oe) else $error("shift not left");
	chk_ana_off: assert property (@(posedge i_tck) disable iff (i_srst)
		dis [*6] |-> !o_ana_drv) else $error("analog driven");
	chk_reset_hiz: assert property (@(posedge i_tck) disable iff (i_srst)
		dis [*6] ##0 !i_reset_pin_n && o_core_reset |-> o_pad_oe == '0) else $error("pads on in reset");
endmodule // bst_tap_assertions

bind bst_tap bst_tap_assertions #(.NPINS(NPINS), .IDCODE(IDCODE)) bst_tap_assertions_inst (
	.i_clk(i_clk),
	.i_srst(i_srst),
	.i_tck(i_tck),
	.i_tms(i_tms),
	.i_tdi(i_tdi),
	.o_tdo(o_tdo),
	.o_tdo_oe(o_tdo_oe),
	.i_tap_enable_fuse(i_tap_enable_fuse),
	.i_tap_disable_bit(i_tap_disable_bit),
	.i_reset_pin_n(i_reset_pin_n),
	.i_core_drive(i_core_drive),
	.o_core_in(o_core_in),
	.i_pad_in(i_pad_in),
	.o_pad_out(o_pad_out),
	.o_pad_oe(o_pad_oe),
	.i_ana_obs(i_ana_obs),
	.o_ana_drv(o_ana_drv),
	.o_core_reset(o_core_reset)
);

/* File: bst_jtag_ctrl.sv */
// test controller model driving the scan port
`timescale 1ns/100ps
module bst_jtag_ctrl (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// tdo moved on the last falling edge, so it is taken at the rising one
	task automatic step(input logic ms, input logic di, output logic d);
		o_tms = ms;
		o_tdi = di;
		#7.5 o_tck = 1'b1;
		d = i_tdo;
		#7.5 o_tck = 1'b0;
	endtask
	task automatic reset5();
		logic d;
		repeat (5) step(1'b1, ~o_tdi, d);
		step(1'b0, ~o_tdi, d);
	endtask
	// idle to idle; tdi is inverted outside the shift so stale data never passes
	task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] q);
		logic d;
		q = '0;
		step(1'b1, ~o_tdi, d);
		if (ir) step(1'b1, ~o_tdi, d);
		step(1'b0, ~o_tdi, d);
		step(1'b0, ~o_tdi, d);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], q[i]);
		step(1'b1, ~o_tdi, d);
		step(1'b0, ~o_tdi, d);
	endtask
endmodule // bst_jtag_ctrl

/* File: bst_tap_bench.sv */
// self-checking bench for the boundary-scan access port
`timescale 1ns/100ps
module bst_tap_bench;
	import bst_pkg::*;
	logic i_clk, i_srst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, i_ana_obs, o_ana_drv, o_core_reset;
	logic i_tap_enable_fuse, i_tap_disable_bit, i_reset_pin_n, hold;
	bst_drive_t [7:0] i_core_drive;
	logic [7:0] o_core_in, i_pad_in, o_pad_out, o_pad_oe, cap;
	logic [63:0] q, pre;
	int failures, comparisons, cyc;
	bst_tap bst_tap_inst (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_tck(i_tck),
		.i_tms(i_tms),
		.i_tdi(i_tdi),
		.o_tdo(o_tdo),
		.o_tdo_oe(o_tdo_oe),
		.i_tap_enable_fuse(i_tap_enable_fuse),
		.i_tap_disable_bit(i_tap_disable_bit),
		.i_reset_pin_n(i_reset_pin_n),
		.i_core_drive(i_core_drive),
		.o_core_in(o_core_in),
		.i_pad_in(i_pad_in),
		.o_pad_out(o_pad_out),
		.o_pad_oe(o_pad_oe),
		.i_ana_obs(i_ana_obs),
		.o_ana_drv(o_ana_drv),
		.o_core_reset(o_core_reset)
	);
	bst_jtag_ctrl bst_jtag_ctrl_inst (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));
	always #25 i_clk = hold ? i_clk : ~i_clk;
	always @(posedge i_clk) if (++cyc > 20000) begin
		failures++;
		results();
	end
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	task automatic ir(input logic [3:0] c);
		bst_jtag_ctrl_inst.scan(1, 4, {60'h0, c}, q);
	endtask
	task automatic dr(input int n, input logic [63:0] d);
		bst_jtag_ctrl_inst.scan(0, n, d, q);
		for (int p = 0; p < 8; p++) cap[p] = q[3*p];
	endtask
	task automatic t_id();
		hold = 1'b1;
		// the port starts disabled: the tck-side state has no reset pin of its own
		bst_jtag_ctrl_inst.reset5();
		chk("off at start", 64'({o_tdo_oe, o_tdo}), 64'h0);
		i_tap_enable_fuse = 1'b1;
		bst_jtag_ctrl_inst.reset5();
		dr(32, 64'h0);
		chk("idcode", 64'(q[31:0]), 64'(BST_IDCODE_VAL));
		hold = 1'b0;
		bst_jtag_ctrl_inst.reset5();
		ir(BST_IR_BYPASS);
		chk("ir capture", 64'(q[3:0]), 64'(BST_IR_CAPTURE));
		dr(9, 64'h01A5);
		chk("bypass", 64'(q[8:0]), (64'h01A5 << 1) & 64'h01FF);
		$display("id test done");
	endtask
	task automatic t_bsr();
		pre = 64'h0;
		for (int p = 0; p < 8; p++) pre[3*p+1 +: 2] = {1'b1, ~p[0]};
		pre[25] = 1'b1;
		ir(BST_IR_SAMPLE);
		dr(26, pre);
		chk("sample", 64'({q[24], cap, o_pad_oe, o_pad_out}), 64'({i_ana_obs, i_pad_in, 16'h55AA}));
		ir(BST_IR_EXTEST);
		chk("extest drive", 64'({o_ana_drv, o_pad_oe, o_pad_out}), 64'h1_FF55);
		tick(1);
		i_pad_in = 8'h3C;
		i_ana_obs = 1'b0;
		dr(26, pre);
		chk("extest capture", 64'({q[24], cap}), 64'h003C);
		$display("chain test done");
	endtask
	task automatic t_rst();
		ir(BST_IR_CORE_RESET);
		dr(1, 64'h1);
		tick(4);
		chk("reset by instr", 64'({o_core_reset, o_pad_oe}), 64'h0100);
		dr(1, 64'h0);
		tick(4);
		chk("instr released", 64'(o_core_reset), 64'h0);
		i_reset_pin_n = 1'b0;
		tick(3);
		chk("reset by pin", 64'({o_core_reset, o_pad_oe}), 64'h0100);
		i_reset_pin_n = 1'b1;
		$display("reset test done");
	endtask
	task automatic t_off();
		logic d;
		for (int k = 0; k < 3; k++) begin
			tick(1);
			{i_tap_enable_fuse, i_tap_disable_bit} = 2'(k == 2 ? 3 : k);
			i_reset_pin_n = (k != 1);
			repeat (12) bst_jtag_ctrl_inst.step(1'b0, 1'b0, d);
			chk("port off", 64'({o_tdo_oe, o_tdo}), 64'h0);
		end
		tick(1);
		{i_tap_enable_fuse, i_tap_disable_bit, i_reset_pin_n} = 3'b101;
		repeat (3) bst_jtag_ctrl_inst.step(1'b0, 1'b0, d);
		dr(32, 64'h0);
		chk("id after enable", 64'(q[31:0]), 64'(BST_IDCODE_VAL));
		$display("enable test done");
	endtask
	initial begin
		i_clk = 1'b0;
		hold = 1'b0;
		i_srst = 1'b1;
		{i_tap_enable_fuse, i_tap_disable_bit, i_reset_pin_n, i_ana_obs} = 4'b0011;
		i_core_drive = 16'h9999;
		i_pad_in = 8'hA5;
		tick(10);
		i_srst = 1'b0;
		t_id();
		t_bsr();
		t_rst();
		t_off();
		results();
	end
endmodule // bst_tap_bench
